// ### clksel_defs.vh
`ifndef CLKSEL_DEFS_VH
`define CLKSEL_DEFS_VH

// Register byte offsets on the bus
`define ADDR_W 4
`define OFS_CLKSEL 4'h0
`define OFS_TRIM 4'h4
`define OFS_STATUS 4'h8
`define OFS_SLEEP 4'hc

// Field positions
`define F_SRC_LO 0
`define F_SRC_HI 3
`define F_SUT_LO 4
`define F_SUT_HI 5
`define F_BUSY 8
`define F_SLEEP 0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Source selection codes
`define SRC_EXT 4'h0
`define SRC_RC 4'h2
`define SRC_WDT 4'h3

// Factory defaults
`define SRC_DEFAULT 4'h2
`define SUT_DEFAULT 2'h2
`define TRIM_RESET 8'h00

// Fuse levels: zero is programmed
`define FUSE_PROG 1'b0

// Startup field codes
`define SUT_00 2'h0
`define SUT_01 2'h1
`define SUT_10 2'h2

// Source index of the oscillator inputs
`define IX_EXT 3'h0
`define IX_RC 3'h1
`define IX_WDT 3'h2
`define IX_LFX 3'h3
`define IX_XTAL 3'h4
`define IX_NONE 3'h7
`define N_OSC 5

// Pin roles
`define ROLE_GPIO 2'h0
`define ROLE_CLKIN 2'h1
`define ROLE_OSC 2'h2

// Cycle counts of the timed oscillator
`define CK_FAST 16'h0006
`define CK_RESET 16'h000e
`define CK_258 16'h0102
`define CK_1K 16'h0400
`define CK_16K 16'h4000
`define CK_32K 16'h8000
`define CK_NONE 16'h0000
`define WDT_SHORT 16'h0200
`define WDT_LONG 16'h2000

`endif

// ### tick_timer.v
`include "clksel_defs.vh"

// Counts ticks of one oscillator up to a limit
module tick_timer (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Control
  input wire start,
  input wire tick,
  input wire [15:0] limit,
  // Status
  output wire busy,
  output reg done_r
);

reg [15:0] remain_r;
reg busy_r;

assign busy = busy_r;

// A zero limit finishes without waiting for any tick
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    remain_r <= `CK_NONE;
    busy_r <= 1'b0;
    done_r <= 1'b0;
  end else begin
    done_r <= 1'b0;
    if (start) begin
      remain_r <= limit;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (remain_r == `CK_NONE) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end else if (tick) begin
        remain_r <= remain_r - 16'h0001;
      end
    end
  end
end

endmodule // tick_timer

// ### clock_source_select.v
// Operation
// R01: The 4-bit source code selects external clock, 8 MHz RC, 128 kHz watchdog oscillator, low-frequency crystal or crystal ranges.
// R02: Each source sets the roles of port_b_pin_four and port_b_pin_five, crystal modes making both oscillator pins.
// R03: A fuse bit at one is unprogrammed and at zero is programmed.
// R04: Wake-up from sleep and a dynamic switch wait a start-up count of the selected clock before execution resumes.
// R05: After reset a further delay of 512 or 8192 watchdog oscillator cycles is added.
// R06: At reset the fuses are copied into the dynamic clock select register, which then steers source and start-up.
// R07: Factory default is the RC source, start-up code 10 and divide-by-eight programmed.
// R08: At reset the calibration value loads the RC trim register, which software may overwrite.
// R09: The watchdog oscillator keeps running even while the RC oscillator is the system clock.
// R10: RC source uses 6 cycles from sleep and a reset delay of 14 cycles, plus 4.1 ms for code 01.
// R11: Watchdog source uses 6 cycles from sleep and 14 cycles plus nothing, 4.1 ms or 65 ms for codes 00, 01, 10.
// R12: Start-up code 00 without real-time delay is honoured only while the reset-pin-disable fuse is unprogrammed.
// R13: A programmed divide-by-eight fuse divides the internal oscillator by 8.
// R14: The asynchronous timer keeps its own clock domain so it counts through sleep.
// R15: The converter keeps its own running clock while CPU and I/O clocks halt.
// R16: External interrupt pins are watched on the free-running clock so they wake the part with I/O clock stopped.
// R17: Unlisted source codes such as 0001 are ignored and the active source is kept.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`include "clksel_defs.vh"

module clock_source_select #(
  parameter [15:0] WDT_LONG_CYC = `WDT_LONG,
  parameter [15:0] XTAL_SLOW_CYC = `CK_16K,
  parameter [15:0] LFX_SLOW_CYC = `CK_32K
) (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Fuses and calibration, static after power-up
  input wire [3:0] source_select_fuses,
  input wire [1:0] startup_time_fuses,
  input wire divide_by_eight_fuse,
  input wire reset_pin_disable_fuse,
  input wire [7:0] cal_byte,
  // Oscillator levels: ext, rc, watchdog, low-freq crystal, crystal
  input wire [4:0] osc_in,
  // External interrupt wake pin
  input wire ext_int_pin,
  // AXI4-Lite write address and data
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Clock system controls
  output reg [3:0] active_source_r,
  output reg [7:0] rc_trim_register,
  output reg sys_clk_div8_r,
  output reg cpu_run_r,
  output reg io_clk_run_r,
  output reg wdt_osc_run_r,
  output reg asy_clk_run_r,
  output reg adc_clk_run_r,
  output reg [1:0] port_b_pin_four_role_r,
  output reg [1:0] port_b_pin_five_role_r
);

localparam [2:0] ST_LOAD = 3'h0;
localparam [2:0] ST_RST_CK = 3'h1;
localparam [2:0] ST_RST_WDT = 3'h2;
localparam [2:0] ST_RUN = 3'h3;
localparam [2:0] ST_SLEEP = 3'h4;
localparam [2:0] ST_WAKE = 3'h5;
localparam [2:0] ST_SWITCH = 3'h6;

////////////////////////////////////////////////////////////////////////////////
// Decode functions

// Maps a source code onto its oscillator input
function [2:0] src_index;
  input [3:0] c;
  begin
    casez (c)
      4'b0000: src_index = `IX_EXT; // see R01
      4'b0010: src_index = `IX_RC;
      4'b0011: src_index = `IX_WDT;
      4'b01??: src_index = `IX_LFX;
      4'b1???: src_index = `IX_XTAL;
      default: src_index = `IX_NONE; // see R17
    endcase
  end
endfunction

// Start-up count from sleep or on a switch, in cycles of the source
function [15:0] pd_cycles;
  input [3:0] c;
  input [1:0] s;
  begin
    case (src_index(c))
      `IX_LFX: pd_cycles = (s == `SUT_10) ? LFX_SLOW_CYC : `CK_1K;
      `IX_XTAL: begin
        if ({c[0], s} <= 3'h1)
          pd_cycles = `CK_258;
        else if ({c[0], s} <= 3'h4)
          pd_cycles = `CK_1K;
        else
          pd_cycles = XTAL_SLOW_CYC;
      end
      default: pd_cycles = `CK_FAST; // see R10, R11
    endcase
  end
endfunction

// Fixed clock part of the reset delay
function [15:0] rst_ck_cycles;
  input [3:0] c;
  begin
    rst_ck_cycles = (src_index(c) == `IX_LFX) ? `CK_NONE : `CK_RESET;
  end
endfunction

// Watchdog-timed part of the reset delay; nodly is the 00-style option
function [15:0] rst_wdt_cycles;
  input [3:0] c;
  input [1:0] s;
  input rpd;
  reg [15:0] v;
  reg nodly;
  begin
    v = WDT_LONG_CYC;
    nodly = 1'b0;
    case (src_index(c))
      `IX_LFX: v = (s == `SUT_00) ? `WDT_SHORT : WDT_LONG_CYC;
      `IX_XTAL: begin
        case ({c[0], s})
          3'h0, 3'h3, 3'h6: v = `WDT_SHORT;
          3'h2, 3'h5: nodly = 1'b1;
          default: v = WDT_LONG_CYC;
        endcase
      end
      default: begin
        // RC default code 10 takes the longest delay
        case (s)
          `SUT_00: nodly = 1'b1; // see R10, R11
          `SUT_01: v = `WDT_SHORT; // see R05
          default: v = WDT_LONG_CYC;
        endcase
      end
    endcase
    // Without a reset pin the no-delay option falls back to the short delay
    if (nodly)
      v = (rpd == `FUSE_PROG) ? `WDT_SHORT : `CK_NONE; // see R12
    rst_wdt_cycles = v;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; oscillator levels become one-cycle ticks

wire [5:0] raw_in;
reg [5:0] sync1_r;
reg [5:0] sync2_r;
reg [4:0] prev_r;
wire [4:0] osc_tick;

assign raw_in = {ext_int_pin, osc_in};

genvar gi;
generate
  for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
    // Two stages, only the second one is read by logic
    always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        sync1_r[gi] <= 1'b0;
        sync2_r[gi] <= 1'b0;
      end else begin
        sync1_r[gi] <= raw_in[gi];
        sync2_r[gi] <= sync1_r[gi];
      end
    end
  end
  for (gi = 0; gi < `N_OSC; gi = gi + 1) begin : g_tick
    always @(posedge mclk or negedge rstn) begin
      if (!rstn)
        prev_r[gi] <= 1'b0;
      else
        prev_r[gi] <= sync2_r[gi];
    end
    assign osc_tick[gi] = sync2_r[gi] & ~prev_r[gi];
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Dynamic clock select register and control state

reg [3:0] dyn_src_r;
reg [1:0] dyn_sut_r;
reg [1:0] act_sut_r;
reg switch_pend_r;
reg sleep_pend_r;
reg [2:0] state_r;
reg tmr_start_r;
reg [15:0] tmr_limit_r;
wire tmr_busy;
wire tmr_done;
reg tmr_tick;

// Bus write handshake: both channels taken in the same cycle
wire wr_go;
wire rd_go;
wire wr_clksel;
wire wr_sleep;

assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
assign s_axi_arready = ~s_axi_rvalid;
assign wr_clksel = wr_go & s_axi_wstrb[0] & (s_axi_awaddr == `OFS_CLKSEL);
assign wr_sleep = wr_go & s_axi_wstrb[0] & (s_axi_awaddr == `OFS_SLEEP) & s_axi_wdata[`F_SLEEP];

// Tick of the clock being timed in each phase
always @* begin
  case (state_r)
    ST_RST_WDT: tmr_tick = osc_tick[`IX_WDT]; // see R05
    ST_SWITCH: tmr_tick = osc_tick[src_index(dyn_src_r)]; // see R04
    default: tmr_tick = osc_tick[src_index(active_source_r)];
  endcase
end

tick_timer u_timer (
  .mclk(mclk),
  .rstn(rstn),
  .start(tmr_start_r),
  .tick(tmr_tick),
  .limit(tmr_limit_r),
  .busy(tmr_busy),
  .done_r(tmr_done)
);

// Sequencer: load fuses, reset delay, run, sleep, wake and switch
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    state_r <= ST_LOAD;
    dyn_src_r <= `SRC_DEFAULT; // see R07
    dyn_sut_r <= `SUT_DEFAULT;
    active_source_r <= `SRC_DEFAULT;
    act_sut_r <= `SUT_DEFAULT;
    rc_trim_register <= `TRIM_RESET;
    sys_clk_div8_r <= 1'b1;
    switch_pend_r <= 1'b0;
    sleep_pend_r <= 1'b0;
    tmr_start_r <= 1'b0;
    tmr_limit_r <= `CK_NONE;
  end else begin
    tmr_start_r <= 1'b0;
    // A new request in the cycle it is consumed still stands
    if (wr_sleep)
      sleep_pend_r <= 1'b1;
    else if (state_r == ST_RUN && sleep_pend_r)
      sleep_pend_r <= 1'b0;
    if (wr_clksel && src_index(s_axi_wdata[`F_SRC_HI:`F_SRC_LO]) != `IX_NONE) begin
      dyn_src_r <= s_axi_wdata[`F_SRC_HI:`F_SRC_LO]; // see R17
      dyn_sut_r <= s_axi_wdata[`F_SUT_HI:`F_SUT_LO];
      switch_pend_r <= 1'b1;
    end else if (state_r == ST_RUN && switch_pend_r && !sleep_pend_r) begin
      switch_pend_r <= 1'b0;
    end
    if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == `OFS_TRIM && state_r != ST_LOAD)
      rc_trim_register <= s_axi_wdata[7:0]; // see R08
    case (state_r)
      ST_LOAD: begin
        // Fuses are only sampled once the reset has been released
        dyn_src_r <= (src_index(source_select_fuses) == `IX_NONE) ? `SRC_DEFAULT : source_select_fuses; // see R06
        dyn_sut_r <= startup_time_fuses;
        active_source_r <= (src_index(source_select_fuses) == `IX_NONE) ? `SRC_DEFAULT : source_select_fuses; // see R17
        act_sut_r <= startup_time_fuses;
        rc_trim_register <= cal_byte; // see R08
        sys_clk_div8_r <= (divide_by_eight_fuse == `FUSE_PROG); // see R03, R13
        tmr_limit_r <= rst_ck_cycles(source_select_fuses);
        tmr_start_r <= 1'b1;
        state_r <= ST_RST_CK;
      end
      ST_RST_CK: begin
        if (tmr_done) begin
          tmr_limit_r <= rst_wdt_cycles(active_source_r, act_sut_r, reset_pin_disable_fuse);
          tmr_start_r <= 1'b1;
          state_r <= ST_RST_WDT;
        end
      end
      ST_RST_WDT: begin
        if (tmr_done)
          state_r <= ST_RUN;
      end
      ST_RUN: begin
        if (sleep_pend_r) begin
          state_r <= ST_SLEEP;
        end else if (switch_pend_r) begin
          tmr_limit_r <= pd_cycles(dyn_src_r, dyn_sut_r); // see R04
          tmr_start_r <= 1'b1;
          state_r <= ST_SWITCH;
        end
      end
      ST_SLEEP: begin
        if (sync2_r[`N_OSC]) begin
          tmr_limit_r <= pd_cycles(active_source_r, act_sut_r); // see R16, R04
          tmr_start_r <= 1'b1;
          state_r <= ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (tmr_done)
          state_r <= ST_RUN;
      end
      ST_SWITCH: begin
        if (tmr_done) begin
          active_source_r <= dyn_src_r; // see R06
          act_sut_r <= dyn_sut_r;
          state_r <= ST_RUN;
        end
      end
      default: state_r <= ST_LOAD;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Clock gating and pin roles

// Watchdog, async timer and converter clocks survive sleep on purpose
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    cpu_run_r <= 1'b0;
    io_clk_run_r <= 1'b0;
    wdt_osc_run_r <= 1'b1;
    asy_clk_run_r <= 1'b0;
    adc_clk_run_r <= 1'b0;
  end else begin
    cpu_run_r <= (state_r == ST_RUN); // see R04
    io_clk_run_r <= (state_r != ST_SLEEP) && (state_r != ST_LOAD);
    wdt_osc_run_r <= 1'b1; // see R09
    asy_clk_run_r <= (state_r != ST_LOAD); // see R14
    adc_clk_run_r <= (state_r != ST_LOAD); // see R15
  end
end

// Pin roles follow the source that is actually running
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    port_b_pin_four_role_r <= `ROLE_GPIO;
    port_b_pin_five_role_r <= `ROLE_GPIO;
  end else begin
    case (src_index(active_source_r))
      `IX_EXT: begin
        port_b_pin_four_role_r <= `ROLE_CLKIN; // see R02
        port_b_pin_five_role_r <= `ROLE_GPIO;
      end
      `IX_LFX, `IX_XTAL: begin
        port_b_pin_four_role_r <= `ROLE_OSC; // see R02
        port_b_pin_five_role_r <= `ROLE_OSC;
      end
      default: begin
        port_b_pin_four_role_r <= `ROLE_GPIO;
        port_b_pin_five_role_r <= `ROLE_GPIO;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Bus responses

// Write response one cycle after both channels are taken
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
  end else if (wr_go) begin
    s_axi_bvalid <= 1'b1;
    s_axi_bresp <= (s_axi_awaddr == `OFS_STATUS) ? `RESP_SLVERR : `RESP_OKAY;
  end else if (s_axi_bready) begin
    s_axi_bvalid <= 1'b0;
  end
end

// Read data registered; unmapped offsets answer zero with an error
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `RESP_OKAY;
  end else if (rd_go) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp <= `RESP_OKAY;
    s_axi_rdata <= 32'h0000_0000;
    case (s_axi_araddr)
      `OFS_CLKSEL: s_axi_rdata <= {23'h000000, switch_pend_r | (state_r == ST_SWITCH), 2'h0, dyn_sut_r, dyn_src_r};
      `OFS_TRIM: s_axi_rdata <= {24'h000000, rc_trim_register};
      `OFS_STATUS: s_axi_rdata <= {18'h00000, port_b_pin_five_role_r, port_b_pin_four_role_r,
                                   sys_clk_div8_r, state_r, act_sut_r, active_source_r};
      `OFS_SLEEP: s_axi_rdata <= {31'h00000000, sleep_pend_r};
      default: s_axi_rresp <= `RESP_SLVERR;
    endcase
  end else if (s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

endmodule // clock_source_select

// ### clksel_monitor.sv
module clksel_monitor (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Fuse
  input wire divide_by_eight_fuse,
  // Bus handshake
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Clock system state
  input wire [3:0] active_source_r,
  input wire sys_clk_div8_r,
  input wire cpu_run_r,
  input wire io_clk_run_r,
  input wire wdt_osc_run_r,
  input wire asy_clk_run_r,
  input wire adc_clk_run_r,
  input wire [1:0] port_b_pin_four_role_r,
  input wire [1:0] port_b_pin_five_role_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  // Transfers accepted by the slave
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready && !s_axi_rvalid;
  endsequence
  property p_wr_answer; s_wr_taken |=> s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  ////////////////////////////////////////////////////////////////
  // Clock system; roles lag the source by one cycle, hence the stable guard
  property p_wdt_run; wdt_osc_run_r; endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog oscillator stopped");
  property p_side_clk; $past(rstn, 2) |-> asy_clk_run_r && adc_clk_run_r; endproperty
  a_side_clk: assert property (p_side_clk) else $error("side clock domain halted");
  property p_div8; $past(rstn, 3) |-> sys_clk_div8_r == !divide_by_eight_fuse; endproperty
  a_div8: assert property (p_div8) else $error("divider does not follow fuse");
  property p_no_invalid; active_source_r != 4'h1; endproperty
  a_no_invalid: assert property (p_no_invalid) else $error("invalid source taken");
  property p_sleep_halt; !io_clk_run_r |-> !cpu_run_r; endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("cpu runs without io clock");
  property p_role_osc;
    $stable(active_source_r) && cpu_run_r && active_source_r[3:2] != 2'h0 |->
      port_b_pin_four_role_r == 2'h2 && port_b_pin_five_role_r == 2'h2;
  endproperty
  a_role_osc: assert property (p_role_osc) else $error("crystal pin roles wrong");
  property p_role_ext;
    $stable(active_source_r) && cpu_run_r && active_source_r == 4'h0 |->
      port_b_pin_four_role_r == 2'h1 && port_b_pin_five_role_r == 2'h0;
  endproperty
  a_role_ext: assert property (p_role_ext) else $error("external clock pin roles wrong");
endmodule // clksel_monitor

bind clock_source_select clksel_monitor u_clksel_monitor (.mclk, .rstn, .divide_by_eight_fuse,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .active_source_r, .sys_clk_div8_r, .cpu_run_r, .io_clk_run_r, .wdt_osc_run_r, .asy_clk_run_r,
  .adc_clk_run_r, .port_b_pin_four_role_r, .port_b_pin_five_role_r);

// ### osc_model.sv
module osc_model (
  // Oscillator levels toward the block
  output logic [4:0] osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // All sources free-run at 60 ns, off phase with the system clock
  initial begin
    osc_in = 5'h00;
    #7;
    forever #30 osc_in = ~osc_in;
  end
endmodule // osc_model

// ### testbench.sv
`include "clksel_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 6;
  localparam logic [7:0] CAL = 8'h5a;
  logic mclk, rstn, ext_int_pin, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, d;
  logic [3:0] src_fuse;
  logic [1:0] sut_fuse;
  logic rpd_fuse, div_fuse;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, div8, cpu_run, io_run, asy_run, adc_run, wdt_run;
  wire [1:0] bresp, rresp, role4, role5;
  wire [31:0] rdata;
  wire [3:0] active;
  wire [7:0] trim;
  wire [4:0] osc_in;
  int fails, tests_run;
  ////////////////////////////////////////////////////////////////
  // Block, with long counts shortened, and its oscillators
  clock_source_select #(.WDT_LONG_CYC(16'h0010), .XTAL_SLOW_CYC(16'h0014), .LFX_SLOW_CYC(16'h0014))
  u_clock_source_select (.mclk(mclk), .rstn(rstn), .source_select_fuses(src_fuse), .startup_time_fuses(sut_fuse),
    .divide_by_eight_fuse(div_fuse), .reset_pin_disable_fuse(rpd_fuse), .cal_byte(CAL), .osc_in(osc_in),
    .ext_int_pin(ext_int_pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .active_source_r(active), .rc_trim_register(trim),
    .sys_clk_div8_r(div8), .cpu_run_r(cpu_run), .io_clk_run_r(io_run), .wdt_osc_run_r(wdt_run),
    .asy_clk_run_r(asy_run), .adc_clk_run_r(adc_run), .port_b_pin_four_role_r(role4),
    .port_b_pin_five_role_r(role5));
  osc_model u_osc_model (.osc_in(osc_in));
  ////////////////////////////////////////////////////////////////
  // Shared helpers
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task close_out;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Address and data offered together; ready is held until the answer is sampled
  task wr(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(posedge mclk); while (!(awready && wready));
    awvalid <= 1'b0; wvalid <= 1'b0;
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp; bready <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata; r = rresp; rready <= 1'b0;
  endtask
  task wait_run(output int n);
    n = 0;
    do begin @(posedge mclk); n++; end while (cpu_run !== 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    int n;
    repeat (4) @(posedge mclk);
    chk("src in reset", 32'h2, 32'(active));
    chk("div8 in reset", 32'h1, 32'(div8));
    rstn <= 1'b1;
    wait_run(n);
    chk("reset delay", 32'h1, 32'(n >= 30 * TICK - 12 && n <= 30 * TICK + 30));
    chk("trim", 32'(CAL), 32'(trim));
    chk("div8", 32'h1, 32'(div8));
    chk("side clocks", 32'h3, 32'({asy_run, adc_run}));
    chk("wdt osc", 32'h1, 32'(wdt_run));
    chk("src", 32'h2, 32'(active));
  endtask
  task t_regs;
    rd(`OFS_CLKSEL);
    chk("clksel", 32'h22, 32'(d[5:0]));
    wr(`OFS_TRIM, 32'ha5);
    rd(`OFS_TRIM);
    chk("trim rd", 32'ha5, 32'(d[7:0]));
    chk("trim port", 32'ha5, 32'(trim));
    wr(`OFS_STATUS, 32'h0);
    chk("status wr", 32'(`RESP_SLVERR), 32'(r));
    rd(`OFS_STATUS);
    chk("status src", 32'h2, 32'(d[3:0]));
  endtask
  // Unlisted code is acknowledged but must leave the source alone
  task t_invalid;
    wr(`OFS_CLKSEL, 32'h21);
    chk("bad code resp", 32'(`RESP_OKAY), 32'(r));
    repeat (40) @(posedge mclk);
    chk("bad code src", 32'h2, 32'(active));
    chk("bad code run", 32'h1, 32'(cpu_run));
  endtask
  task sw(input logic [3:0] c, input logic [1:0] s, input logic [1:0] r4, input logic [1:0] r5, input int t);
    int n;
    wr(`OFS_CLKSEL, {26'h0, s, c});
    do @(posedge mclk); while (cpu_run !== 1'b0);
    wait_run(n);
    chk("startup", 32'h1, 32'(n >= t * TICK - 12 && n <= t * TICK + 30));
    repeat (2) @(posedge mclk);
    chk("new src", 32'(c), 32'(active));
    chk("pin4 role", 32'(r4), 32'(role4));
    chk("pin5 role", 32'(r5), 32'(role5));
  endtask
  // Sleep holds until the wake pin, then the active source is timed again
  task t_sleep;
    int n;
    wr(`OFS_SLEEP, 32'h1);
    do @(posedge mclk); while (io_run !== 1'b0);
    repeat (20) @(posedge mclk);
    chk("asleep", 32'h0, 32'(cpu_run));
    chk("wdt osc asleep", 32'h1, 32'(wdt_run));
    ext_int_pin <= 1'b1;
    wait_run(n);
    ext_int_pin <= 1'b0;
    chk("wake time", 32'h1, 32'(n <= 6 * TICK + 30));
    chk("io clock", 32'h1, 32'(io_run));
  endtask
  // Mid-run reset with new fuses: reset delay, divider, pins and copied fields
  task t_boot(input logic [3:0] c, input logic [1:0] s, input logic p, input logic f, input int t,
              input logic [1:0] r4, input logic [1:0] r5);
    int n;
    rstn <= 1'b0; src_fuse <= c; sut_fuse <= s; rpd_fuse <= p; div_fuse <= f;
    repeat (4) @(posedge mclk);
    chk("cpu in reset", 32'h0, 32'(cpu_run));
    rstn <= 1'b1;
    wait_run(n);
    chk("boot delay", 32'h1, 32'(n >= t * TICK - 12 && n <= t * TICK + 30));
    chk("boot src", 32'(c), 32'(active));
    chk("boot div8", 32'(!f), 32'(div8));
    chk("boot pins", 32'({r5, r4}), 32'({role5, role4}));
    chk("boot trim", 32'(CAL), 32'(trim));
    rd(`OFS_CLKSEL);
    chk("boot clksel", 32'({s, c}), 32'(d[5:0]));
  endtask
  ////////////////////////////////////////////////////////////////
  // Clock, main sequence and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rstn = 1'b0; ext_int_pin = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hf;
    src_fuse = 4'h2; sut_fuse = 2'h2; rpd_fuse = 1'b1; div_fuse = 1'b0;
    fails = 0; tests_run = 0;
    t_reset;
    t_regs;
    t_invalid;
    sw(4'h0, 2'h0, 2'h1, 2'h0, 6);
    sw(4'h9, 2'h1, 2'h2, 2'h2, 20);
    sw(4'hc, 2'h0, 2'h2, 2'h2, 258);
    sw(4'h4, 2'h2, 2'h2, 2'h2, 20);
    sw(4'h3, 2'h0, 2'h0, 2'h0, 6);
    sw(4'h2, 2'h1, 2'h0, 2'h0, 6);
    t_sleep;
    t_boot(4'h2, 2'h0, 1'b1, 1'b1, 14, 2'h0, 2'h0);
    t_boot(4'h2, 2'h0, 1'b0, 1'b1, 526, 2'h0, 2'h0);
    t_boot(4'h7, 2'h1, 1'b1, 1'b0, 16, 2'h2, 2'h2);
    close_out;
  end
  // Whole run needs about 5600 cycles
  initial begin
    #400000;
    fails++;
    $display("ERROR watchdog expected end seen hang");
    close_out;
  end
endmodule // testbench
